// [fsdr_master_model.sv]
// fsdr_master_model: frame sink standing in for the fieldbus master.
// assumes the byte stream of fsdr_records, everything on clk_sys.
`timescale 1ns/10ps
module fsdr_master_model (
    input  wire logic         clk_sys,  // 100 MHz clock
    input  wire logic         resetn,   // async reset, low
    input  wire logic         slow,     // stall every other cycle
    input  wire logic         tx_valid, // frame byte valid
    input  wire logic [7:0]   tx_data,  // frame byte
    input  wire logic         tx_last,  // last frame byte
    output logic              tx_ready, // byte accepted
    output logic [119:0]      frm,      // last frame, byte 0 high
    output logic [4:0]        frm_len,  // its byte count
    output logic [15:0]       frm_cnt   // frames seen
);
    logic [119:0] acc;
    logic [4:0]   n;
    // collect bytes; stalls make the design hold each byte longer
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_ready <= 1'b0;
            acc      <= '0;
            n        <= '0;
            frm      <= '0;
            frm_len  <= '0;
            frm_cnt  <= '0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                acc <= {acc[111:0], tx_data};
                n   <= n + 5'h01;
                if (tx_last) begin
                    // left align so standard byte 0 sits on top
                    frm     <= {acc[111:0], tx_data} << (8 * (14 - int'(n)));
                    frm_len <= n + 5'h01;
                    frm_cnt <= frm_cnt + 16'h0001;
                    acc     <= '0;
                    n       <= '0;
                end
            end
        end
    end
endmodule // fsdr_master_model

// [fsdr_pkg.sv]
// fsdr_pkg: constants and types of the diagnostic record framer.
// assumes one 100 MHz clock; nothing else depends on the surroundings.
package fsdr_pkg;
    localparam int         DEPTH     = 100;      // ring entries
    localparam logic [6:0] LAST_IDX  = 7'h63;    // last ring index
    localparam logic [7:0] SLOT_NONE = 8'h00;
    localparam logic [7:0] SLOT_MAX  = 8'h20;
    localparam logic [7:0] MODE_STD  = 8'h00;
    localparam logic [7:0] MODE_EXT  = 8'h01;
    localparam logic [4:0] STD_LAST  = 5'h05;    // last standard byte
    localparam logic [4:0] HDR_POS   = 5'h06;    // header byte position
    // message codes
    localparam logic [7:0] C_PRM     = 8'h0a;
    localparam logic [7:0] C_CFGL    = 8'h14;
    localparam logic [7:0] C_CFGE    = 8'h15;
    localparam logic [7:0] C_PWR     = 8'h1e;
    localparam logic [7:0] C_BPCFG   = 8'h28;
    localparam logic [7:0] C_BPINI   = 8'h29;
    localparam logic [7:0] C_BPBUS   = 8'h2a;
    localparam logic [7:0] C_RDY     = 8'h3d;
    localparam logic [7:0] C_DX      = 8'h3e;
    // reported lengths
    localparam logic [4:0] L_PRM     = 5'h08;
    localparam logic [4:0] L_CFG     = 5'h06;
    localparam logic [4:0] L_BPCFG   = 5'h03;
    localparam logic [4:0] L_SHORT   = 5'h02;
    // event sources, lowest index wins
    localparam int S_PRM  = 0;
    localparam int S_CFGL = 1;
    localparam int S_CFGE = 2;
    localparam int S_BOOT = 3;
    localparam int S_PNOW = 4;
    localparam int S_BPC  = 5;
    localparam int S_BPI  = 6;
    localparam int S_BPB  = 7;
    localparam int S_RDY  = 8;
    localparam int S_DX   = 9;
    localparam int NSRC   = 10;
    // time stamp base
    localparam int CLK_NS      = 10;
    localparam int TICK_NS     = 1000000;   // 1 ms stamp unit
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } fsdr_tx_e;
endpackage

// [fsdr_records.sv]
// fsdr_records: builds, stores and frames device diagnostic records.
// assumes all inputs synchronous to clk_sys; tx_ready from the bus side.
`timescale 1ns/10ps
module fsdr_records #(
    parameter int TICK_CYCLES = fsdr_pkg::TICK_CYCLES // stamp divider
) (
    input  wire logic        clk_sys,      // 100 MHz clock
    input  wire logic        resetn,       // async reset, low
    input  wire logic        prm_valid,    // parameter message seen
    input  wire logic [7:0]  prm_len,      // received user length
    input  wire logic [7:0]  prm_len_exp,  // expected user length
    input  wire logic [7:0]  prm_mode,     // 0 standard, 1 extended
    input  wire logic [7:0]  prm_dig_cnt,  // slave digital modules
    input  wire logic [7:0]  prm_ana_cnt,  // slave analog modules
    input  wire logic [7:0]  prm_ana_mst,  // master analog modules
    input  wire logic        cfg_valid,    // configuration length check
    input  wire logic [7:0]  cfg_len_mst,  // master quantity
    input  wire logic [7:0]  cfg_len_slv,  // default quantity
    input  wire logic [7:0]  cfg_mode,     // 0 standard, 1 extended
    input  wire logic        ent_valid,    // one entry pair to compare
    input  wire logic [7:0]  ent_mst,      // master identifier
    input  wire logic [7:0]  ent_slv,      // default identifier
    input  wire logic        pwr_fail,     // power drop detected, level
    input  wire logic        nv_ts_valid,  // stamp found at restart
    input  wire logic [31:0] nv_ts_in,     // stamp from nonvolatile
    input  wire logic        bp_cfg_fail,  // slot configuration failed
    input  wire logic [7:0]  bp_slot,      // failing slot
    input  wire logic        bp_init_fail, // backplane init failed
    input  wire logic        bp_bus_fault, // backplane bus fault
    input  wire logic        st_ready,     // status became ready
    input  wire logic        st_dx,        // status became exchange
    input  wire logic [47:0] std_diag,     // standard bytes, byte 0 high
    input  wire logic        tx_ready,     // frame sink accepts
    output logic             tx_valid,     // frame byte valid
    output logic [7:0]       tx_data,      // frame byte
    output logic             tx_last,      // last frame byte
    output logic             nv_save,      // save stamp, pulse
    output logic [31:0]      nv_ts,        // stamp to save
    input  wire logic        rd_req,       // read one record
    input  wire logic [6:0]  rd_age,       // 0 = newest
    output logic             rd_valid,     // read answer, pulse
    output logic             rd_hit,       // record exists
    output logic [63:0]      rd_rec,       // bytes 0..7
    output logic [31:0]      rd_stamp,     // its time stamp
    output logic [4:0]       rd_len,       // its reported length
    output logic [6:0]       rec_count     // records held
);
    typedef struct packed {
        logic [99:0][95:0]   mem;
        logic [6:0]          wr_ptr;
        logic [6:0]          count;
        logic [9:0]          pend;
        logic [39:0]         prm_pl;
        logic [23:0]         cfgl_pl;
        logic [23:0]         cfge_pl;
        logic [7:0]          slot;
        logic [31:0]         boot_ts;
        logic                len_ok;
        logic                booted;
        logic                pwr_q;
        logic [16:0]         tick;
        logic [31:0]         ts;
        logic                tx_pend;
        logic [63:0]         tx_rec;
        logic [63:0]         tx_cur;
        logic [47:0]         tx_std;
        fsdr_pkg::fsdr_tx_e  tx_state;
        logic [4:0]          pos;
        logic                tx_valid;
        logic [7:0]          tx_data;
        logic                tx_last;
        logic                nv_save;
        logic [31:0]         nv_ts;
        logic                rd_valid;
        logic                rd_hit;
        logic [63:0]         rd_rec;
        logic [31:0]         rd_stamp;
        logic [4:0]          rd_len;
    } fsdr_st_s;

    fsdr_st_s    st;
    fsdr_st_s    next_st;
    logic [1:0]  rsync;
    logic        rst_n;
    logic [9:0]  evt;
    logic [9:0]  gnt;
    logic [63:0] rec;
    logic        do_store;
    logic [7:0]  ridx;

    // reported length per code
    function automatic logic [4:0] rec_len(input logic [7:0] code);
        case (code)
            fsdr_pkg::C_PRM:   rec_len = fsdr_pkg::L_PRM;
            fsdr_pkg::C_CFGL:  rec_len = fsdr_pkg::L_CFG;
            fsdr_pkg::C_CFGE:  rec_len = fsdr_pkg::L_CFG;
            fsdr_pkg::C_BPCFG: rec_len = fsdr_pkg::L_BPCFG;
            default:           rec_len = fsdr_pkg::L_SHORT;
        endcase
    endfunction

    // codes that never leave the device
    function automatic logic internal(input logic [7:0] code);
        internal = (code == fsdr_pkg::C_RDY) || (code == fsdr_pkg::C_DX);
    endfunction

    // frame byte at a position; record bytes past the stored eight are zero
    function automatic logic [7:0] frame_byte(input logic [47:0] sd,
                                              input logic [63:0] r,
                                              input logic [4:0]  p);
        logic [4:0] k;
        k = p - 5'h07;
        if (p <= fsdr_pkg::STD_LAST) begin
            frame_byte = sd[8*(5-p) +: 8];
        end else if (p == fsdr_pkg::HDR_POS) begin
            frame_byte = {3'b000, rec_len(r[63:56]) + 5'h01};
        end else if (k < 5'h08) begin
            frame_byte = r[8*(7-k) +: 8];
        end else begin
            frame_byte = 8'h00;
        end
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rsync <= 2'b00;
        end else begin
            rsync <= {rsync[0], 1'b1};
        end
    end
    assign rst_n = rsync[1];

    always_comb begin
        next_st = st;
        next_st.nv_save = 1'b0;
        next_st.rd_valid = 1'b0;
        evt = '0;
        rec = '0;
        ridx = 8'h00;
        // millisecond time base
        if (st.tick == 17'(TICK_CYCLES - 1)) begin
            next_st.tick = 17'h0;
            next_st.ts = st.ts + 32'h1;
        end else begin
            next_st.tick = st.tick + 17'h1;
        end
        // event detection and payload capture
        if (prm_valid && (prm_len != prm_len_exp)) begin
            evt[fsdr_pkg::S_PRM] = 1'b1;
            next_st.prm_pl = {prm_len, prm_mode, prm_dig_cnt,
                              prm_ana_cnt, prm_ana_mst};
        end
        if (cfg_valid) begin
            next_st.len_ok = (cfg_len_mst == cfg_len_slv);
            if (cfg_len_mst != cfg_len_slv) begin
                evt[fsdr_pkg::S_CFGL] = 1'b1;
                next_st.cfgl_pl = {cfg_len_mst, cfg_mode, cfg_len_slv};
            end
        end
        // entries only count once the lengths agreed
        if (ent_valid && st.len_ok && (ent_mst != ent_slv)) begin
            evt[fsdr_pkg::S_CFGE] = 1'b1;
            next_st.cfge_pl = {ent_mst, cfg_mode, ent_slv};
        end
        // restart: stamp left by a power drop becomes a record
        if (!st.booted) begin
            next_st.booted = 1'b1;
            evt[fsdr_pkg::S_BOOT] = nv_ts_valid;
            next_st.boot_ts = nv_ts_in;
        end
        // power drop: stamp out first, record goes to the frame only
        next_st.pwr_q = pwr_fail;
        if (pwr_fail && !st.pwr_q) begin
            next_st.nv_save = 1'b1;
            next_st.nv_ts = st.ts;
            evt[fsdr_pkg::S_PNOW] = 1'b1;
        end
        if (bp_cfg_fail) begin
            evt[fsdr_pkg::S_BPC] = 1'b1;
            next_st.slot = (bp_slot != fsdr_pkg::SLOT_NONE &&
                            bp_slot <= fsdr_pkg::SLOT_MAX) ?
                           bp_slot : fsdr_pkg::SLOT_NONE;
        end
        evt[fsdr_pkg::S_BPI] = bp_init_fail;
        evt[fsdr_pkg::S_BPB] = bp_bus_fault;
        evt[fsdr_pkg::S_RDY] = st_ready;
        evt[fsdr_pkg::S_DX] = st_dx;
        // one record per cycle, others wait; a new event beats the clear
        gnt = st.pend & (~st.pend + 10'h1);
        next_st.pend = (st.pend & ~gnt) | evt;
        case (gnt)
            10'h001: rec = {fsdr_pkg::C_PRM, fsdr_pkg::SLOT_NONE,
                            st.prm_pl, 8'h00};
            10'h002: rec = {fsdr_pkg::C_CFGL, fsdr_pkg::SLOT_NONE,
                            st.cfgl_pl, 24'h0};
            10'h004: rec = {fsdr_pkg::C_CFGE, fsdr_pkg::SLOT_NONE,
                            st.cfge_pl, 24'h0};
            10'h008: rec = {fsdr_pkg::C_PWR, fsdr_pkg::SLOT_NONE, 48'h0};
            10'h010: rec = {fsdr_pkg::C_PWR, fsdr_pkg::SLOT_NONE, 48'h0};
            10'h020: rec = {fsdr_pkg::C_BPCFG, st.slot, 48'h0};
            10'h040: rec = {fsdr_pkg::C_BPINI, fsdr_pkg::SLOT_NONE, 48'h0};
            10'h080: rec = {fsdr_pkg::C_BPBUS, fsdr_pkg::SLOT_NONE, 48'h0};
            10'h100: rec = {fsdr_pkg::C_RDY, fsdr_pkg::SLOT_NONE, 48'h0};
            10'h200: rec = {fsdr_pkg::C_DX, fsdr_pkg::SLOT_NONE, 48'h0};
            default: rec = '0;
        endcase
        do_store = (|gnt) && !gnt[fsdr_pkg::S_PNOW];
        // frame sender: frees its slot before a new record claims it
        case (st.tx_state)
            fsdr_pkg::TX_IDLE: begin
                if (st.tx_pend) begin
                    next_st.tx_pend = 1'b0;
                    next_st.tx_cur = st.tx_rec;
                    next_st.tx_std = std_diag;
                    next_st.pos = 5'h00;
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data = std_diag[47:40];
                    next_st.tx_last = 1'b0;
                    next_st.tx_state = fsdr_pkg::TX_SEND;
                end
            end
            fsdr_pkg::TX_SEND: begin
                if (tx_ready) begin
                    if (st.tx_last) begin
                        next_st.tx_valid = 1'b0;
                        next_st.tx_last = 1'b0;
                        next_st.tx_state = fsdr_pkg::TX_IDLE;
                    end else begin
                        next_st.pos = st.pos + 5'h01;
                        next_st.tx_data = frame_byte(st.tx_std, st.tx_cur,
                                                     st.pos + 5'h01);
                        next_st.tx_last = (st.pos + 5'h01) ==
                            (fsdr_pkg::HDR_POS + rec_len(st.tx_cur[63:56]));
                    end
                end
            end
            default: begin
                next_st.tx_state = fsdr_pkg::TX_IDLE;
                next_st.tx_valid = 1'b0;
            end
        endcase
        // newest outgoing record replaces one still waiting
        if ((|gnt) && !internal(rec[63:56])) begin
            next_st.tx_pend = 1'b1;
            next_st.tx_rec = rec;
        end
        // ring write; full ring drops the oldest
        if (do_store) begin
            next_st.mem[st.wr_ptr] = {rec, gnt[fsdr_pkg::S_BOOT] ?
                                      st.boot_ts : st.ts};
            next_st.wr_ptr = (st.wr_ptr == fsdr_pkg::LAST_IDX) ?
                             7'h00 : st.wr_ptr + 7'h01;
            if (st.count != 7'(fsdr_pkg::DEPTH)) begin
                next_st.count = st.count + 7'h01;
            end
        end
        // read by age, newest first
        if (rd_req) begin
            ridx = {1'b0, st.wr_ptr} + 8'(fsdr_pkg::DEPTH - 1) - {1'b0, rd_age};
            if (ridx >= 8'(fsdr_pkg::DEPTH)) begin
                ridx = ridx - 8'(fsdr_pkg::DEPTH);
            end
            next_st.rd_valid = 1'b1;
            next_st.rd_hit = rd_age < st.count;
            if (rd_age < st.count) begin
                next_st.rd_rec = st.mem[ridx[6:0]][95:32];
                next_st.rd_stamp = st.mem[ridx[6:0]][31:0];
                next_st.rd_len = rec_len(st.mem[ridx[6:0]][95:88]);
            end else begin
                next_st.rd_rec = '0;
                next_st.rd_stamp = '0;
                next_st.rd_len = 5'h00;
            end
        end
    end

    // whole state in one register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.tx_state <= fsdr_pkg::TX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign tx_valid  = st.tx_valid;
    assign tx_data   = st.tx_data;
    assign tx_last   = st.tx_last;
    assign nv_save   = st.nv_save;
    assign nv_ts     = st.nv_ts;
    assign rd_valid  = st.rd_valid;
    assign rd_hit    = st.rd_hit;
    assign rd_rec    = st.rd_rec;
    assign rd_stamp  = st.rd_stamp;
    assign rd_len    = st.rd_len;
    assign rec_count = st.count;

    // checks on the design's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        st.tx_state == fsdr_pkg::TX_IDLE && st.tx_pend;
    endsequence
    property p_std_first;
        s_start |=> st.tx_valid && st.tx_data == $past(std_diag[47:40]);
    endproperty
    a_std_first: assert property (p_std_first)
        else $error("frame does not open with standard byte 0");
    property p_hdr;
        st.tx_valid && st.pos == fsdr_pkg::HDR_POS |->
            st.tx_data == {3'b000, rec_len(st.tx_cur[63:56]) + 5'h01};
    endproperty
    a_hdr: assert property (p_hdr)
        else $error("header byte wrong");
    property p_last;
        st.tx_valid && st.tx_last |->
            st.pos == fsdr_pkg::HDR_POS + rec_len(st.tx_cur[63:56]);
    endproperty
    a_last: assert property (p_last)
        else $error("frame length wrong");
    property p_count;
        st.count <= 7'(fsdr_pkg::DEPTH);
    endproperty
    a_count: assert property (p_count)
        else $error("record count above ring size");
    property p_wrap;
        do_store && st.wr_ptr == fsdr_pkg::LAST_IDX |=> st.wr_ptr == 7'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("write pointer did not wrap");
    property p_store;
        do_store |=> st.mem[$past(st.wr_ptr)][95:32] == $past(rec);
    endproperty
    a_store: assert property (p_store)
        else $error("record not stored");
    property p_internal;
        do_store && internal(rec[63:56]) && !st.tx_pend |=> !st.tx_pend;
    endproperty
    a_internal: assert property (p_internal)
        else $error("internal record queued for sending");
    property p_prm;
        prm_valid && prm_len != prm_len_exp |=> st.pend[fsdr_pkg::S_PRM];
    endproperty
    a_prm: assert property (p_prm)
        else $error("parameter error not raised");
    property p_entry;
        ent_valid && !st.len_ok && !st.pend[fsdr_pkg::S_CFGE] |=>
            !st.pend[fsdr_pkg::S_CFGE];
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry error raised without length match");
    property p_nv;
        pwr_fail && !st.pwr_q |=> nv_save && nv_ts == $past(st.ts);
    endproperty
    a_nv: assert property (p_nv)
        else $error("stamp not saved on power drop");
endmodule // fsdr_records

// [tb_fieldbus_slave_diag_records.sv]
// tb_fieldbus_slave_diag_records: self-checking bench of fsdr_records.
// assumes fsdr_pkg and fsdr_master_model compiled before it.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); num_errors++; end end
module tb_fieldbus_slave_diag_records;
    typedef struct packed {
        logic [7:0]  ev;
        logic [39:0] arg;
        logic [63:0] rec;
        logic [4:0]  len;
    } fsdr_row_s;
    localparam logic [47:0] STD = 48'h112233445566;
    logic clk_sys = 1'b0, resetn = 1'b0, slow = 1'b0, pwr_fail = 1'b0, nv_ts_valid = 1'b0;
    logic rd_req = 1'b0;
    logic [31:0] nv_ts_in = '0;
    logic [6:0]  rd_age = '0;
    logic [7:0]  ev = '0, lexp = 8'h10;
    logic [39:0] arg = '0;
    logic tx_valid, tx_last, tx_ready, nv_save, rd_valid, rd_hit;
    logic [7:0] tx_data;
    logic [31:0] nv_ts, rd_stamp, s0;
    logic [63:0] rd_rec;
    logic [4:0] rd_len, frm_len;
    logic [6:0] rec_count;
    logic [119:0] frm;
    logic [15:0] frm_cnt, c0;
    int num_errors = 0, tests_run = 0, cyc = 0;
    fsdr_row_s rows [9] = '{
        '{8'h01, 40'h0500020301, 64'h0a00050002030100, 5'h08},
        '{8'h01, 40'h2001040002, 64'h0a00200104000200, 5'h08},
        '{8'h02, 40'h0301050000, 64'h1400030105000000, 5'h06},
        '{8'h04, 40'h1100220000, 64'h1500110022000000, 5'h06},
        '{8'h08, 40'h0500000000, 64'h2805000000000000, 5'h03},
        '{8'h08, 40'h2000000000, 64'h2820000000000000, 5'h03},
        '{8'h08, 40'h2100000000, 64'h2800000000000000, 5'h03},
        '{8'h10, 40'h0000000000, 64'h2900000000000000, 5'h02},
        '{8'h20, 40'h0000000000, 64'h2a00000000000000, 5'h02}};
    fsdr_records #(.TICK_CYCLES(4)) i_fsdr_records (
        .clk_sys(clk_sys), .resetn(resetn), .prm_valid(ev[0]), .prm_len(arg[39:32]),
        .prm_len_exp(lexp), .prm_mode(arg[31:24]), .prm_dig_cnt(arg[23:16]),
        .prm_ana_cnt(arg[15:8]), .prm_ana_mst(arg[7:0]), .cfg_valid(ev[1]),
        .cfg_len_mst(arg[39:32]), .cfg_len_slv(arg[23:16]), .cfg_mode(arg[31:24]),
        .ent_valid(ev[2]), .ent_mst(arg[39:32]), .ent_slv(arg[23:16]),
        .pwr_fail(pwr_fail), .nv_ts_valid(nv_ts_valid), .nv_ts_in(nv_ts_in),
        .bp_cfg_fail(ev[3]), .bp_slot(arg[39:32]), .bp_init_fail(ev[4]),
        .bp_bus_fault(ev[5]), .st_ready(ev[6]), .st_dx(ev[7]), .std_diag(STD),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .nv_save(nv_save), .nv_ts(nv_ts), .rd_req(rd_req), .rd_age(rd_age),
        .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_rec(rd_rec), .rd_stamp(rd_stamp),
        .rd_len(rd_len), .rec_count(rec_count));
    fsdr_master_model i_fsdr_master_model (
        .clk_sys(clk_sys), .resetn(resetn), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .frm(frm),
        .frm_len(frm_len), .frm_cnt(frm_cnt));
    always #5 clk_sys = ~clk_sys;
    // hang guard, well above the longest expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one-cycle event pulse with its payload
    task automatic fire(input logic [7:0] e, input logic [39:0] a);
        @(posedge clk_sys);
        ev  <= e;
        arg <= a;
        @(posedge clk_sys);
        ev  <= 8'h00;
    endtask
    task automatic read_rec(input logic [6:0] age);
        @(posedge clk_sys);
        rd_req <= 1'b1;
        rd_age <= age;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            #1;
            if (rd_valid === 1'b1) break;
            @(posedge clk_sys);
        end
        `CHK("read valid", 1'b1, rd_valid)
    endtask
    // wait up to 400 cycles for the frame count to move, then compare the frame and its length
    task automatic wait_frame(input logic [15:0] c, input logic [63:0] rec,
                              input logic [4:0] len);
        for (int n = 0; n < 400 && frm_cnt === c; n++) @(posedge clk_sys);
        #1;
        `CHK("frame", {STD, 3'b000, len + 5'h01, rec}, frm)
        `CHK("frame length", len + 5'h07, frm_len)
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        `CHK("reset tx_valid", 1'b0, tx_valid)
        `CHK("reset count", 7'h00, rec_count)
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // ordinary records, alternating prompt and stalling master
        for (int i = 0; i < 9; i++) begin
            slow <= i[0];
            c0 = frm_cnt;
            if (rows[i].ev == 8'h04) fire(8'h02, {8'h04, rows[i].arg[31:24], 8'h04, 16'h0});
            fire(rows[i].ev, rows[i].arg);
            wait_frame(c0, rows[i].rec, rows[i].len);
            read_rec(7'h00);
            `CHK("stored rec", rows[i].rec, rd_rec)
            `CHK("stored len", rows[i].len, rd_len)
            `CHK("count", 7'(i + 1), rec_count)
        end
        $display("test rows done");
        // matching checks make nothing; status records stay internal
        c0 = frm_cnt;
        fire(8'h01, 40'h1000000000);
        fire(8'h02, 40'h0400040000);
        fire(8'h40, 40'h0);
        fire(8'h80, 40'h0);
        repeat (40) @(posedge clk_sys);
        `CHK("no frame", c0, frm_cnt)
        `CHK("count internal", 7'h0b, rec_count)
        read_rec(7'h00);
        `CHK("newest code", 8'h3e, rd_rec[63:56])
        s0 = rd_stamp;
        read_rec(7'h01);
        `CHK("older code", 8'h3d, rd_rec[63:56])
        $display("test internal done");
        // power drop: stamp saved at once, record sent but not stored
        c0 = frm_cnt;
        @(posedge clk_sys);
        pwr_fail <= 1'b1;
        for (int n = 0; n < 4 && nv_save !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK("save pulse", 1'b1, nv_save)
        `CHK("save stamp later", 1'b1, nv_ts > s0)
        @(posedge clk_sys);
        #1;
        `CHK("save ends", 1'b0, nv_save)
        wait_frame(c0, 64'h1e00000000000000, 5'h02);
        `CHK("count power", 7'h0b, rec_count)
        pwr_fail <= 1'b0;
        $display("test power done");
        // restart with a saved stamp stores the power record
        @(posedge clk_sys);
        resetn      <= 1'b0;
        nv_ts_valid <= 1'b1;
        nv_ts_in    <= 32'h00123456;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        nv_ts_valid <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHK("count restart", 7'h01, rec_count)
        read_rec(7'h00);
        `CHK("restart rec", 64'h1e00000000000000, rd_rec)
        `CHK("restart stamp", 32'h00123456, rd_stamp)
        `CHK("restart len", 5'h02, rd_len)
        $display("test restart done");
        // overfill the ring while the master stalls
        slow <= 1'b1;
        for (int k = 0; k < 105; k++) begin
            fire(8'h20, 40'h0);
            @(posedge clk_sys);
        end
        repeat (10) @(posedge clk_sys);
        `CHK("count full", 7'h64, rec_count)
        read_rec(7'h63);
        `CHK("oldest hit", 1'b1, rd_hit)
        `CHK("oldest code", 8'h2a, rd_rec[63:56])
        read_rec(7'h64);
        `CHK("beyond miss", 1'b0, rd_hit)
        $display("test ring done");
        finish_test();
    end
endmodule // tb_fieldbus_slave_diag_records
